/* tlf_pkg.sv */
// tlf_pkg: constants, types and helpers of the transparent link framer
package tlf_pkg;
  // register offsets
  localparam logic [3:0] A_MODE = 4'h0;
  localparam logic [3:0] A_CMD = 4'h1;
  localparam logic [3:0] A_CHSEL = 4'h2;
  localparam logic [3:0] A_DATA = 4'h3;
  localparam logic [3:0] A_RSTAT = 4'h4;
  localparam logic [3:0] A_TOP_IRQ = 4'h5;
  localparam logic [3:0] A_FR_IRQ = 4'h6;
  localparam logic [3:0] A_FR_MASK = 4'h7;
  localparam logic [3:0] A_TEST = 4'h8;
  localparam logic [3:0] A_TCFG = 4'h9;
  localparam logic [3:0] A_LEVEL = 4'hA;
  // mode register fields
  localparam int OPM_LSB = 0;
  localparam int OPM_MSB = 2;
  localparam logic [2:0] MODE_TRANSP = 3'h4;
  localparam int BAM_LSB = 4;
  localparam int BAM_MSB = 5;
  localparam logic [1:0] BAM_COLL = 2'h1;
  // command bits
  localparam int CMD_SEND = 0;
  localparam int CMD_END = 1;
  localparam int CMD_TRES = 2;
  // channel enables and frame slots
  localparam int CH_D = 0;
  localparam int CH_B1 = 1;
  localparam int CH_B2 = 2;
  localparam logic [1:0] SLOT_B1 = 2'h0;
  localparam logic [1:0] SLOT_B2 = 2'h1;
  localparam logic [1:0] SLOT_D = 2'h2;
  // interrupt bits, then loop and disable bits
  localparam int IRQ_RXB = 0;
  localparam int IRQ_RFO = 1;
  localparam int IRQ_XDU = 4;
  localparam int IRQ_XMR = 5;
  localparam int IRQ_XPR = 6;
  localparam int TOP_FR = 0;
  localparam int TLOOP_BIT = 0;
  localparam int TDIS_BIT = 0;
  // fifo geometry
  localparam int FIFO_AW = 6;
  localparam logic [6:0] FIFO_DEPTH = 7'h40;
  // link timing
  localparam int SYS_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 800;
  localparam int LINK_DIV = LINK_PERIOD_NS / SYS_PERIOD_NS;
  localparam logic [2:0] DIV_RISE = 3'(LINK_DIV / 2 - 1);
  localparam logic [4:0] BIT_FIRST = 5'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // synchroniser lanes
  localparam int SY_DCL = 0;
  localparam int SY_FSC = 1;
  localparam int SY_DIN = 2;
  localparam int SY_SG = 3;
  localparam int SY_W = 4;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01,
    TX_SEND = 2'b10
  } tlf_tx_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tlf_bus_t;

  typedef struct packed {
    tlf_tx_state_t st;
    logic [2:0] div;
    logic dcl_o;
    logic dcl_prev;
    logic fsc_o;
    logic l1_oe;
    logic [4:0] bitcnt;
    logic du;
    logic [7:0] tsh;
    logic [7:0] rsh;
    logic [5:0] twp;
    logic [5:0] trp;
    logic [6:0] tcnt;
    logic [6:0] tcom;
    logic eom;
    logic lock;
    logic rx_on;
    logic [5:0] rwp;
    logic [5:0] rrp;
    logic [6:0] rcnt;
    logic [7:0] rstat;
    logic [7:0] mode;
    logic [7:0] chsel;
    logic [7:0] test;
    logic [7:0] tcfg;
    logic [7:0] fr_irq;
    logic [7:0] fr_mask;
    logic [7:0] rdata;
    logic irq;
    logic [63:0][7:0] tmem;
    logic [63:0][7:0] rmem;
  } tlf_state_t;

  localparam tlf_state_t STATE_RST = '0;

  // true when the frame slot belongs to an enabled channel
  function automatic logic chan_on(input logic [7:0] sel, input logic [1:0] slot);
    chan_on = (slot == SLOT_B1 && sel[CH_B1]) || (slot == SLOT_B2 && sel[CH_B2])
      || (slot == SLOT_D && sel[CH_D]);
  endfunction
endpackage

/* tlf_sync.sv */
// tlf_sync: two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module tlf_sync #(
  parameter int W = 4
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // tlf_sync
`default_nettype wire

/* tlf_framer.sv */
// tlf_framer: transparent layer-2 framer on a time-slot serial link
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE1] op_mode 100 selects transparent: no flags, no crc, no stuffing
// [RULE2] transmitter shifts fifo bytes out unchanged, byte and frame aligned
// [RULE3] sending starts in first enabled channel of the next link frame
// [RULE4] send plus end: pool-ready after last byte, then idle ones
// [RULE5] collision mode 1 makes stop/go a clear-to-send gate
// [RULE6] stop during sending always raises the repeat interrupt
// [RULE7] fifo empty mid-message without end raises the underrun interrupt
// [RULE8] reception is byte aligned, from first enabled channel of next frame
// [RULE9] each received byte goes to rx fifo and rx status register; here a byte meeting a full fifo sets overflow instead of entering it
// [RULE10] fifo levels, interrupts and commands act as in framed modes
// [RULE11] any pending framer source sets the top summary bit; here only unmasked sources set it
// [RULE12] a one in the mask register hides that framer source
// [RULE13] loop bit feeds the transmit bit stream into the receiver
// [RULE14] while looped the downstream data pin is ignored
// [RULE15] transceiver disable stops internal link clock and frame generation; here the divider runs on and bit timing switches to the pins
// [RULE16] while disabled, clock and frame sync pins are inputs
// [RULE17] repeat or underrun flush tx fifo and lock writes until read
// [RULE18] channel select bits pick D, B1, B2 in any combination
// [RULE19] interrupt output high while an unmasked framer bit is set
module tlf_framer (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire tlf_pkg::tlf_bus_t bus,
  output logic [7:0] rdata,
  output logic irq,
  input wire logic data_clock_in,
  output logic data_clock_out,
  output logic data_clock_oe,
  input wire logic frame_sync_in,
  output logic frame_sync_out,
  output logic frame_sync_oe,
  input wire logic downstream_data_pin,
  output logic upstream_data,
  input wire logic stop_go_bit
);
  import tlf_pkg::*;

  tlf_state_t s;
  tlf_state_t n;
  logic [SY_W-1:0] sy;
  logic ext;
  logic transp;
  logic coll;
  logic cts;
  logic tick;
  logic fstart;
  logic [4:0] nbit;
  logic slot_now;
  logic rx_bit;
  logic rx_push;
  logic [7:0] rx_byte;
  logic rpop;
  logic tpush;
  logic tpop;
  logic commit;
  logic flush;
  logic [7:0] irq_set;
  logic [7:0] irq_clr;
  logic [7:0] tbyte;

  // pins from the far side pass two flops before use
  tlf_sync #(.W(SY_W)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .d({stop_go_bit, downstream_data_pin, frame_sync_in, data_clock_in}),
    .q(sy)
  );

  // next-state logic; section order sets priority, later wins
  always_comb begin
    n = s;
    n.rdata = '0;
    irq_set = '0;
    irq_clr = '0;
    rx_push = 1'b0;
    rpop = 1'b0;
    tpush = 1'b0;
    tpop = 1'b0;
    commit = 1'b0;
    flush = 1'b0;
    tbyte = s.tmem[s.trp];
    // [RULE1] transparent mode decode
    transp = s.mode[OPM_MSB:OPM_LSB] == MODE_TRANSP;
    // [RULE5] collision gate from stop/go
    coll = s.mode[BAM_MSB:BAM_LSB] == BAM_COLL;
    cts = !(coll && sy[SY_SG]);
    ext = s.tcfg[TDIS_BIT];
    // [RULE15] link bit timing from own divider or from the pins
    n.div = s.div + 3'h1;
    n.dcl_o = n.div[2];
    n.dcl_prev = sy[SY_DCL];
    tick = ext ? (sy[SY_DCL] && !s.dcl_prev) : (s.div == DIV_RISE);
    nbit = (ext && sy[SY_FSC]) ? BIT_FIRST : s.bitcnt + 5'h01;
    fstart = tick && (nbit == BIT_FIRST);
    // [RULE18] channel enable of the slot now starting
    slot_now = chan_on(s.chsel, nbit[4:3]);
    // [RULE16] pins turn to inputs while layer 1 is off
    n.l1_oe = !n.tcfg[TDIS_BIT];
    // [RULE13] looped stream replaces the pin
    // [RULE14] pin ignored in loop
    rx_bit = s.test[TLOOP_BIT] ? s.du : sy[SY_DIN];
    rx_byte = {s.rsh[6:0], rx_bit};

    // receiver: sample the bit of the slot just ended
    if (tick) begin
      n.bitcnt = nbit;
      n.fsc_o = (nbit == BIT_FIRST);
      // [RULE8] start only at a frame boundary
      if (fstart) begin
        n.rx_on = transp;
      end
      if (s.rx_on && chan_on(s.chsel, s.bitcnt[4:3])) begin
        n.rsh = rx_byte;
        if (s.bitcnt[2:0] == BIT_LAST) begin
          // [RULE9] byte to fifo and status register
          n.rstat = rx_byte;
          irq_set[IRQ_RXB] = 1'b1;
          if (s.rcnt == FIFO_DEPTH) begin
            irq_set[IRQ_RFO] = 1'b1;
          end else begin
            rx_push = 1'b1;
            n.rmem[s.rwp] = rx_byte;
            n.rwp = s.rwp + 6'h01;
          end
        end
      end
    end
    if (!transp) begin
      n.rx_on = 1'b0;
    end

    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        A_MODE: n.mode = bus.wdata;
        A_CHSEL: n.chsel = bus.wdata;
        A_TEST: n.test = bus.wdata;
        A_TCFG: n.tcfg = bus.wdata;
        A_FR_MASK: n.fr_mask = bus.wdata;
        A_FR_IRQ: irq_clr = bus.wdata;
        // [RULE17] writes dropped while locked
        A_DATA: begin
          if (!s.lock && s.tcnt != FIFO_DEPTH) begin
            tpush = 1'b1;
            n.tmem[s.twp] = bus.wdata;
            n.twp = s.twp + 6'h01;
          end
        end
        default: ;
      endcase
    end

    // register reads, data in the following cycle
    if (bus.rd) begin
      unique case (bus.addr)
        A_MODE: n.rdata = s.mode;
        A_CHSEL: n.rdata = s.chsel;
        A_TEST: n.rdata = s.test;
        A_TCFG: n.rdata = s.tcfg;
        A_FR_MASK: n.rdata = s.fr_mask;
        A_RSTAT: n.rdata = s.rstat;
        // [RULE11] summary of pending unmasked sources
        A_TOP_IRQ: n.rdata[TOP_FR] = |(s.fr_irq & ~s.fr_mask);
        // [RULE10] fill level as in framed modes
        A_LEVEL: n.rdata = {1'b0, s.rcnt};
        A_DATA: begin
          if (s.rcnt != 7'h00) begin
            n.rdata = s.rmem[s.rrp];
            rpop = 1'b1;
            n.rrp = s.rrp + 6'h01;
          end
        end
        // [RULE17] reading the errors unlocks the fifo
        A_FR_IRQ: begin
          n.rdata = s.fr_irq;
          irq_clr = s.fr_irq;
          if (s.fr_irq[IRQ_XDU] || s.fr_irq[IRQ_XMR]) begin
            n.lock = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // transmitter
    if (tick) begin
      // [RULE4] idle line is all ones
      n.du = 1'b1;
      unique case (s.st)
        TX_IDLE: n.st = TX_IDLE;
        // [RULE3] wait for next frame start and clear-to-send
        TX_WAIT: begin
          if (fstart && cts && transp) begin
            n.st = TX_SEND;
          end
        end
        // [RULE6] stop while sending forces repeat
        TX_SEND: begin
          if (!cts) begin
            irq_set[IRQ_XMR] = 1'b1;
            flush = 1'b1;
            n.lock = 1'b1;
            n.st = TX_IDLE;
          end
        end
        default: n.st = TX_IDLE;
      endcase
      if (n.st == TX_SEND && slot_now) begin
        if (nbit[2:0] == BIT_FIRST[2:0]) begin
          if (s.tcom != 7'h00) begin
            // [RULE2] byte sent msb first, unchanged
            n.du = tbyte[7];
            n.tsh = {tbyte[6:0], 1'b0};
            tpop = 1'b1;
            n.trp = s.trp + 6'h01;
            n.tcom = s.tcom - 7'h01;
          end else if (s.eom) begin
            // [RULE4] message done, pool ready
            irq_set[IRQ_XPR] = 1'b1;
            n.eom = 1'b0;
            n.st = TX_IDLE;
          end else begin
            // [RULE7] ran dry without end command
            irq_set[IRQ_XDU] = 1'b1;
            flush = 1'b1;
            n.lock = 1'b1;
            n.st = TX_IDLE;
          end
        end else begin
          n.du = s.tsh[7];
          n.tsh = {s.tsh[6:0], 1'b0};
        end
      end
    end

    // [RULE10] commands as in framed modes
    if (bus.wr && bus.addr == A_CMD) begin
      if (bus.wdata[CMD_SEND]) begin
        commit = 1'b1;
        if (bus.wdata[CMD_END]) begin
          n.eom = 1'b1;
        end else begin
          irq_set[IRQ_XPR] = 1'b1;
        end
        if (s.st == TX_IDLE) begin
          n.st = TX_WAIT;
        end
      end
      if (bus.wdata[CMD_TRES]) begin
        flush = 1'b1;
        irq_set[IRQ_XPR] = 1'b1;
        n.st = TX_IDLE;
      end
    end

    // fifo counters; a flush empties the transmit side
    n.rcnt = s.rcnt + {6'h00, rx_push} - {6'h00, rpop};
    n.tcnt = s.tcnt + {6'h00, tpush} - {6'h00, tpop};
    if (commit) begin
      n.tcom = n.tcnt;
    end
    // [RULE17] error flushes tx fifo
    if (flush) begin
      n.twp = '0;
      n.trp = '0;
      n.tcnt = '0;
      n.tcom = '0;
      n.eom = 1'b0;
    end

    // sticky status, set beats clear
    n.fr_irq = (s.fr_irq & ~irq_clr) | irq_set;
    // [RULE12] masked sources never reach the pin
    // [RULE19] level output
    n.irq = |(n.fr_irq & ~n.fr_mask);
  end

  // single state register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s <= STATE_RST;
    end else begin
      s <= n;
    end
  end

  // all outputs straight from state flops
  assign rdata = s.rdata;
  assign irq = s.irq;
  assign data_clock_out = s.dcl_o;
  assign data_clock_oe = s.l1_oe;
  assign frame_sync_out = s.fsc_o;
  assign frame_sync_oe = s.l1_oe;
  assign upstream_data = s.du;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence s_byte_start;
    tick && s.st == TX_SEND && slot_now && nbit[2:0] == BIT_FIRST[2:0];
  endsequence
  sequence s_dry_end;
    s_byte_start ##0 (s.tcom == 7'h00 && s.eom && cts);
  endsequence
  sequence s_dry_open;
    s_byte_start ##0 (s.tcom == 7'h00 && !s.eom && cts);
  endsequence

  a_idle_line_ones: assert property ( // [RULE4]
    (s.st == TX_IDLE && tick) |=> s.du)
    else $error("idle line not high");
  a_end_pool_ready: assert property ( // [RULE4]
    s_dry_end |=> (s.fr_irq[IRQ_XPR] && s.st == TX_IDLE))
    else $error("no pool ready after last byte");
  a_underrun_lock: assert property ( // [RULE7]
    s_dry_open |=> (s.fr_irq[IRQ_XDU] && s.lock && s.tcnt == 7'h00))
    else $error("underrun not flagged");
  a_stop_repeat: assert property ( // [RULE6]
    (tick && s.st == TX_SEND && coll && sy[SY_SG]) |=> (s.fr_irq[IRQ_XMR] && s.lock))
    else $error("stop without repeat");
  a_lock_drops_write: assert property ( // [RULE17]
    (s.lock && bus.wr && bus.addr == A_DATA) |=> s.tcnt == $past(s.tcnt))
    else $error("write taken while locked");
  a_frame_align: assert property ( // [RULE3]
    (s.st == TX_WAIT && tick && !fstart) |=> s.st != TX_SEND)
    else $error("send began off frame start");
  a_rx_store: assert property ( // [RULE9]
    rx_push |=> (s.rstat == $past(rx_byte) && s.rcnt == $past(s.rcnt) + 7'h01 - $past({6'h00, rpop})))
    else $error("received byte not stored");
  a_loop_source: assert property ( // [RULE13]
    s.test[TLOOP_BIT] |-> rx_bit == s.du)
    else $error("loop not from transmit stream");
  a_irq_level: assert property ( // [RULE19]
    irq == |(s.fr_irq & ~s.fr_mask))
    else $error("interrupt level wrong");
  a_read_status: assert property ( // [RULE9]
    (bus.rd && bus.addr == A_RSTAT) |=> rdata == $past(s.rstat))
    else $error("status read wrong");
  a_pins_input: assert property ( // [RULE16]
    s.tcfg[TDIS_BIT] |=> (!data_clock_oe && !frame_sync_oe))
    else $error("pins driven while disabled");
endmodule // tlf_framer
`default_nettype wire

/* tlf_link_model.sv */
// tlf_link_model: layer-1 side of the time-slot serial link
`timescale 1ns/1ps
`default_nettype none
module tlf_link_model (
  input wire logic reset_n,
  input wire logic data_clock_out,
  input wire logic data_clock_oe,
  input wire logic frame_sync_out,
  input wire logic frame_sync_oe,
  input wire logic upstream_data,
  input wire logic stop_req,
  input wire logic [7:0] rx_b1,
  output logic data_clock_pin,
  output logic frame_sync_pin,
  output logic downstream_data_pin,
  output logic stop_go_bit,
  output logic [7:0] tx_b1,
  output logic frm
);
  logic ext_clk = 1'b0;
  logic ext_fsc;
  logic [4:0] ecnt;
  logic [4:0] idx;
  logic [4:0] nidx;
  logic [7:0] sh;
  // link clock of the far side, the link runs free
  always #400 ext_clk = ~ext_clk;
  always @(posedge ext_clk or negedge reset_n) begin
    if (!reset_n) begin
      ecnt <= 5'h00;
      ext_fsc <= 1'b0;
    end else begin
      ecnt <= ecnt + 5'h01;
      ext_fsc <= (ecnt == 5'h1F);
    end
  end
  // pin level from whoever drives it
  assign data_clock_pin = data_clock_oe ? data_clock_out : ext_clk;
  assign frame_sync_pin = frame_sync_oe ? frame_sync_out : ext_fsc;
  assign stop_go_bit = stop_req;
  // work at mid-bit so the edges of either side never race the data
  always @(negedge data_clock_pin or negedge reset_n) begin
    if (!reset_n) begin
      idx <= 5'h00;
      sh <= 8'h00;
      tx_b1 <= 8'hFF;
      frm <= 1'b0;
      downstream_data_pin <= 1'b1;
    end else begin
      nidx = frame_sync_pin ? 5'h00 : idx + 5'h01;
      idx <= nidx;
      sh <= {sh[6:0], upstream_data};
      if (nidx == 5'h07) begin
        tx_b1 <= {sh[6:0], upstream_data};
        frm <= ~frm;
      end
      // first slot carries the byte, msb first; idle ones elsewhere
      downstream_data_pin <= (nidx < 5'h08) ? rx_b1[3'h7 - nidx[2:0]] : 1'b1;
    end
  end
endmodule // tlf_link_model
`default_nettype wire

/* tlf_framer_bench.sv */
// tlf_framer_bench: self-checking bench of the transparent link framer
`timescale 1ns/1ps
`default_nettype none
module tlf_framer_bench;
  import tlf_pkg::*;
  localparam logic [7:0] B_XPR = 8'(1 << IRQ_XPR);
  localparam logic [7:0] B_XDU = 8'(1 << IRQ_XDU);
  localparam logic [7:0] B_XMR = 8'(1 << IRQ_XMR);
  localparam logic [7:0] B_RXQ = 8'((1 << IRQ_RXB) | (1 << IRQ_RFO));
  logic clk_sys, reset_n, irq, dco, dcoe, fso, fsoe, up, data_clock_pin, frame_sync_pin, dd, sg, stop_req, frm;
  logic [7:0] rdata, rx_b1, tx_b1;
  tlf_bus_t bus;
  int num_errors, n_compared;

  tlf_framer tlf_framer_i (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus), .rdata(rdata),
    .irq(irq), .data_clock_in(data_clock_pin), .data_clock_out(dco), .data_clock_oe(dcoe),
    .frame_sync_in(frame_sync_pin), .frame_sync_out(fso), .frame_sync_oe(fsoe),
    .downstream_data_pin(dd), .upstream_data(up), .stop_go_bit(sg));
  tlf_link_model tlf_link_model_i (.reset_n(reset_n), .data_clock_out(dco),
    .data_clock_oe(dcoe), .frame_sync_out(fso), .frame_sync_oe(fsoe), .upstream_data(up),
    .stop_req(stop_req), .rx_b1(rx_b1), .data_clock_pin(data_clock_pin), .frame_sync_pin(frame_sync_pin), .downstream_data_pin(dd),
    .stop_go_bit(sg), .tx_b1(tx_b1), .frm(frm));

  // comparison and bus helpers
  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    @(negedge clk_sys);
    d = rdata;
  endtask
  task automatic chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    cmp(e, v & m);
  endtask
  task automatic frames(input int n);
    repeat (n) @(frm);
    @(posedge clk_sys);
  endtask
  // bounded polls, paced one link frame at a time
  task automatic poll(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    v = ~e;
    for (int i = 0; i < 6 && (v & m) !== e; i++) begin
      frames(1);
      rd(a, v);
    end
    cmp(e, v & m);
  endtask
  task automatic poll_tx(input logic [7:0] e);
    for (int i = 0; i < 4 && tx_b1 !== e; i++) begin
      frames(1);
    end
    cmp(e, tx_b1);
  endtask

  // reset values, read-back, unmapped place, no reception outside the mode
  task automatic t_regs;
    chk(A_MODE, 8'hFF, 8'h00);
    chk(A_FR_IRQ, 8'hFF, 8'h00);
    cmp(8'h00, {7'h00, irq});
    chk(A_LEVEL, 8'hFF, 8'h00);
    wr(A_CHSEL, 8'h07);
    chk(A_CHSEL, 8'hFF, 8'h07);
    wr(4'hB, 8'h5A);
    chk(4'hB, 8'hFF, 8'h00);
    wr(A_CHSEL, 8'h02);
    wr(A_FR_MASK, B_RXQ);
    frames(2);
    chk(A_RSTAT, 8'hFF, 8'h00);
  endtask
  task automatic t_rx;
    wr(A_MODE, 8'(MODE_TRANSP));
    frames(3);
    chk(A_RSTAT, 8'hFF, 8'h5A);
    chk(A_DATA, 8'hFF, 8'h5A);
    chk(A_FR_IRQ, 8'h01, 8'h01);
    chk(A_TOP_IRQ, 8'h01, 8'h00);
    cmp(8'h00, {7'h00, irq});
  endtask
  task automatic t_tx;
    wr(A_DATA, 8'hA5);
    wr(A_DATA, 8'h3C);
    wr(A_CMD, 8'h03);
    poll_tx(8'hA5);
    chk(A_FR_IRQ, B_XPR, 8'h00);
    frames(1);
    cmp(8'h3C, tx_b1);
    frames(1);
    cmp(8'hFF, tx_b1);
    cmp(8'h01, {7'h00, irq});
    chk(A_TOP_IRQ, 8'h01, 8'h01);
    chk(A_FR_IRQ, B_XPR, B_XPR);
    repeat (2) @(posedge clk_sys);
    cmp(8'h00, {7'h00, irq});
  endtask
  // underrun flushes the fifo and drops writes until the status is read
  task automatic t_under;
    wr(A_DATA, 8'h66);
    wr(A_CMD, 8'h01);
    chk(A_FR_IRQ, B_XPR, B_XPR);
    poll_tx(8'h66);
    frames(2);
    wr(A_DATA, 8'h77);
    chk(A_FR_IRQ, B_XDU, B_XDU);
    // transmitter reset empties the fifo and frees the pool at once
    wr(A_DATA, 8'h55);
    wr(A_CMD, 8'h04);
    chk(A_FR_IRQ, B_XPR, B_XPR);
    wr(A_CMD, 8'h03);
    repeat (3) begin
      frames(1);
      cmp(8'hFF, tx_b1);
    end
  endtask
  task automatic t_stop;
    wr(A_MODE, 8'(MODE_TRANSP) | (8'(BAM_COLL) << BAM_LSB));
    stop_req <= 1'b1;
    wr(A_DATA, 8'h11);
    wr(A_DATA, 8'h22);
    wr(A_DATA, 8'h33);
    wr(A_CMD, 8'h03);
    frames(3);
    cmp(8'hFF, tx_b1);
    stop_req <= 1'b0;
    poll_tx(8'h11);
    stop_req <= 1'b1;
    frames(2);
    chk(A_FR_IRQ, B_XMR, B_XMR);
    stop_req <= 1'b0;
    frames(2);
    cmp(8'hFF, tx_b1);
    wr(A_MODE, 8'(MODE_TRANSP));
  endtask
  task automatic t_loop;
    wr(A_TEST, 8'h01);
    frames(3);
    chk(A_RSTAT, 8'hFF, 8'hFF);
    wr(A_DATA, 8'hC3);
    wr(A_CMD, 8'h03);
    poll(A_RSTAT, 8'hFF, 8'hC3);
    wr(A_TEST, 8'h00);
  endtask
  task automatic t_dis;
    wr(A_TCFG, 8'h01);
    repeat (2) @(posedge clk_sys);
    cmp(8'h00, {6'h00, dcoe, fsoe});
    rx_b1 <= 8'h96;
    poll(A_RSTAT, 8'hFF, 8'h96);
  endtask

  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // the tests need some 50 link frames; this is well beyond
  initial begin
    repeat (60000) @(posedge clk_sys);
    num_errors++;
    wrap_up();
  end
  initial begin
    reset_n = 1'b0;
    bus = '0;
    stop_req = 1'b0;
    rx_b1 = 8'h5A;
    num_errors = 0;
    n_compared = 0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs();
    t_rx();
    t_tx();
    t_under();
    t_stop();
    t_loop();
    t_dis();
    wrap_up();
  end
endmodule // tlf_framer_bench
`default_nettype wire
